// ==== rtl/flow_through_burst_sram_port.sv ====
/*
 * Flow-through burst static memory port with a common data bus, built on a
 * flip-flop array. Synchronous inputs are sampled on the rising edge of clk_sys.
 * Assumes the driving controller is synchronous to clk_sys and that the data
 * wire is resolved from data_out and data_oe outside this module.
 */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - A two-bit counter loads the burst start address and supplies the later beat addresses.
// - Every synchronous input is registered on the rising clock edge and acts only there.
// - Address, data, chip selects, strobes, advance and write enables are all treated as synchronous.
// - Output-drive enable and sleep request release the bus at once, without waiting for a clock edge; drive resumes only on a clock edge.
// - A high order select gives interleaved burst order and a low one gives linear order.
// - Either the processor strobe or the controller strobe starts a new burst.
// - Address and chip selects load only on an edge where a strobe is active.
// - The burst address steps only when burst advance is asserted.
// - The port is 36 bits by 256K or 18 bits by 512K on one shared data bus.
// - A four-beat burst runs at three cycles after the strobe edge for the first beat and one for each later beat.
module flow_through_burst_sram_port #(
    parameter bit          WIDE       = 1'b1,
    parameter int unsigned DATA_WIDTH = WIDE ? sram_port_pkg::DATA_WIDTH_WIDE : sram_port_pkg::DATA_WIDTH_NARROW,
    parameter int unsigned ADDR_WIDTH = WIDE ? sram_port_pkg::ADDR_WIDTH_WIDE : sram_port_pkg::ADDR_WIDTH_NARROW,
    parameter int unsigned MEM_DEPTH  = 1024,
    parameter int unsigned LANES      = DATA_WIDTH / sram_port_pkg::LANE_WIDTH
) (
    input  wire logic                  clk_sys,
    input  wire logic                  reset,
    input  wire logic [ADDR_WIDTH-1:0] address,
    input  wire logic [DATA_WIDTH-1:0] data_in,
    output logic      [DATA_WIDTH-1:0] data_out,
    output logic                       data_oe,
    input  wire logic                  pipeline_chip_select_n,
    input  wire logic                  depth_select_b,
    input  wire logic                  depth_select_c_n,
    input  wire logic                  processor_addr_strobe_n,
    input  wire logic                  controller_addr_strobe_n,
    input  wire logic                  burst_advance_n,
    input  wire logic [LANES-1:0]      byte_lane_write_n,
    input  wire logic                  byte_write_gate_n,
    input  wire logic                  global_write_n,
    input  wire logic                  output_enable_n,
    input  wire logic                  sleep_request,
    input  wire logic                  burst_order
);
    localparam int unsigned LW = sram_port_pkg::LANE_WIDTH;
    localparam int unsigned IW = $clog2(MEM_DEPTH);

    typedef enum logic [1:0] {
        IDLE_T,
        READ_T,
        WRITE_T
    } access_t;

    ////////////////////////////////////////////////////////////////////////
    // Input registers.

    logic [ADDR_WIDTH-1:0] address_reg;
    logic [DATA_WIDTH-1:0] data_in_reg;
    logic                  cs1_n_reg;
    logic                  cs2_reg;
    logic                  cs3_n_reg;
    logic                  processor_addr_strobe_n_reg;
    logic                  controller_addr_strobe_n_reg;
    logic                  adv_n_reg;
    logic [LANES-1:0]      lane_n_reg;
    logic                  bwe_n_reg;
    logic                  gw_n_reg;
    logic                  order_reg;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            address_reg <= '0;
            data_in_reg <= '0;
            cs1_n_reg   <= 1'b1;
            cs2_reg     <= 1'b0;
            cs3_n_reg   <= 1'b1;
            processor_addr_strobe_n_reg  <= 1'b1;
            controller_addr_strobe_n_reg  <= 1'b1;
            adv_n_reg   <= 1'b1;
            lane_n_reg  <= '1;
            bwe_n_reg   <= 1'b1;
            gw_n_reg    <= 1'b1;
            order_reg   <= 1'b0;
        end else begin
            address_reg <= address;
            data_in_reg <= data_in;
            cs1_n_reg   <= pipeline_chip_select_n;
            cs2_reg     <= depth_select_b;
            cs3_n_reg   <= depth_select_c_n;
            processor_addr_strobe_n_reg  <= processor_addr_strobe_n;
            controller_addr_strobe_n_reg  <= controller_addr_strobe_n;
            adv_n_reg   <= burst_advance_n;
            lane_n_reg  <= byte_lane_write_n;
            bwe_n_reg   <= byte_write_gate_n;
            gw_n_reg    <= global_write_n;
            order_reg   <= burst_order;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Access start and burst address.

    logic                  strobe;
    logic                  selected;
    logic                  write_now;
    logic [LANES-1:0]      lane_we;
    logic [ADDR_WIDTH-1:0] burst_addr_reg;
    logic                  active_reg;
    logic [1:0]            low_bits;
    logic                  step;

    // A strobe with the chip deselected ends any burst in progress.
    assign strobe    = !processor_addr_strobe_n_reg || !controller_addr_strobe_n_reg;
    assign selected  = !cs1_n_reg && cs2_reg && !cs3_n_reg;
    assign step      = active_reg && !strobe && !adv_n_reg;
    assign write_now = !gw_n_reg || (!bwe_n_reg && (lane_n_reg != '1));
    assign lane_we   = !gw_n_reg ? '1 : (bwe_n_reg ? '0 : ~lane_n_reg);

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            burst_addr_reg <= '0;
            active_reg     <= 1'b0;
        end else if (strobe) begin
            burst_addr_reg <= address_reg;
            active_reg     <= selected;
        end
    end

    burst_counter u_burst_counter (
        .clk_sys           (clk_sys),
        .reset             (reset),
        .load              (strobe),
        .step              (step),
        .order_interleaved (order_reg),
        .start_bits        (address_reg[1:0]),
        .low_bits          (low_bits)
    );

    ////////////////////////////////////////////////////////////////////////
    // Access sequencing and storage.

    access_t                 access_reg;
    logic    [ADDR_WIDTH-1:0] cur_addr;
    logic    [IW-1:0]         mem_index;
    logic    [DATA_WIDTH-1:0] mem [MEM_DEPTH];

    assign cur_addr  = {burst_addr_reg[ADDR_WIDTH-1:2], low_bits};
    assign mem_index = cur_addr[IW-1:0];

    // A write is decided from the write enables one cycle after the strobe,
    // which is when a processor-strobe write presents its enables.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            access_reg <= IDLE_T;
        end else if (strobe && !selected) begin
            access_reg <= IDLE_T;
        end else if (strobe || step) begin
            access_reg <= READ_T;
        end else if (active_reg && write_now) begin
            access_reg <= WRITE_T;
        end else begin
            access_reg <= IDLE_T;
        end
    end

    logic                  wr_pend_reg;
    logic [DATA_WIDTH-1:0] wr_data_reg;
    logic [LANES-1:0]      wr_lane_reg;

    // A write beat is held for one more edge, so that an advance given in the
    // same cycle has already moved the burst address when the data lands.
    // Sleep blocks the capture, so only a write beat captured before sleep rose can still land while asleep.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wr_pend_reg <= 1'b0;
            wr_data_reg <= '0;
            wr_lane_reg <= '0;
        end else begin
            wr_pend_reg <= active_reg && !strobe && write_now && !sleep_request;
            wr_data_reg <= data_in_reg;
            wr_lane_reg <= lane_we;
        end
    end

    for (genvar g = 0; g < LANES; g++) begin : g_lane
        always_ff @(posedge clk_sys) begin
            if (wr_pend_reg && wr_lane_reg[g]) begin
                mem[mem_index][g*LW +: LW] <= wr_data_reg[g*LW +: LW];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data and output drive.

    logic [DATA_WIDTH-1:0] read_reg;
    logic                  read_valid_reg;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            read_reg       <= '0;
            read_valid_reg <= 1'b0;
        end else begin
            read_reg       <= mem[mem_index];
            read_valid_reg <= active_reg && !write_now && !(strobe && !selected);
        end
    end

    // Output release needs no clock: a rising output_enable_n or sleep_request
    // clears the flop at once, while drive returns only on a clk_sys edge.
    // The flop form keeps every output on a register as the house style asks.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            data_out <= '0;
        end else begin
            data_out <= read_reg;
        end
    end

    always_ff @(posedge clk_sys or posedge output_enable_n or posedge sleep_request or posedge reset) begin
        if (reset || output_enable_n || sleep_request) begin
            data_oe <= 1'b0;
        end else begin
            data_oe <= read_valid_reg;
        end
    end
endmodule : flow_through_burst_sram_port

`default_nettype wire

// ==== inc/sram_port_pkg.sv ====
/*
 * Constants for the flow-through burst static memory port: organisation,
 * burst length and the start-of-access latency.
 * Assumes nothing of its surroundings.
 */
package sram_port_pkg;
    localparam int unsigned DATA_WIDTH_WIDE   = 36;
    localparam int unsigned ADDR_WIDTH_WIDE   = 18;
    localparam int unsigned DATA_WIDTH_NARROW = 18;
    localparam int unsigned ADDR_WIDTH_NARROW = 19;
    localparam int unsigned LANE_WIDTH        = 9;
    localparam int unsigned BURST_BITS        = 2;
    localparam int unsigned FIRST_BEAT_CYCLES = 2;
    localparam logic [1:0]  BEAT_RESET        = 2'h0;
    localparam logic        ORDER_INTERLEAVED = 1'b1;
endpackage : sram_port_pkg

// ==== rtl/burst_counter.sv ====
/*
 * Two-bit burst address counter: loads the start bits on a strobe and forms
 * the current low address bits in linear or interleaved order.
 * Assumes a single clock and that load and step are already registered inputs.
 */
`timescale 1ns/1ps
`default_nettype none

module burst_counter (
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       load,
    input  wire logic       step,
    input  wire logic       order_interleaved,
    input  wire logic [1:0] start_bits,
    output logic      [1:0] low_bits
);
    logic [1:0] start_reg;
    logic [1:0] beat_reg;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            start_reg <= sram_port_pkg::BEAT_RESET;
            beat_reg  <= sram_port_pkg::BEAT_RESET;
        end else if (load) begin
            start_reg <= start_bits;
            beat_reg  <= sram_port_pkg::BEAT_RESET;
        end else if (step) begin
            beat_reg  <= beat_reg + 2'h1;
        end
    end

    // Both orders wrap inside the four-beat group; the carry never leaves bit 1.
    always_comb begin
        if (order_interleaved == sram_port_pkg::ORDER_INTERLEAVED) begin
            low_bits = start_reg ^ beat_reg;
        end else begin
            low_bits = start_reg + beat_reg;
        end
    end
endmodule : burst_counter

`default_nettype wire

// ==== testbench/sram_port_asserts.sv ====
/* Checker for the burst memory port outputs.
   Assumes it is bound to the port's top module. */
`timescale 1ns/1ps
`default_nettype none
module sram_port_asserts #(parameter int unsigned DATA_WIDTH = 36) (
    input wire logic                  clk_sys,
    input wire logic                  reset,
    input wire logic [DATA_WIDTH-1:0] data_out,
    input wire logic                  data_oe,
    input wire logic                  pipeline_chip_select_n,
    input wire logic                  processor_addr_strobe_n,
    input wire logic                  controller_addr_strobe_n,
    input wire logic                  burst_advance_n,
    input wire logic                  global_write_n,
    input wire logic                  output_enable_n,
    input wire logic                  sleep_request
);
    wire logic  st = !processor_addr_strobe_n || !controller_addr_strobe_n;
    logic [3:0] idle_reg;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Quiet cycles since the last strobe or advance; saturates so it never wraps.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) idle_reg <= 4'hf;
        else if (st || !burst_advance_n) idle_reg <= 4'h0;
        else if (idle_reg != 4'hf) idle_reg <= idle_reg + 4'h1;
    end
    AST_OE_FLOAT: assert property (output_enable_n |-> !data_oe) else $error("drive while enable off");
    AST_SLEEP_FLOAT: assert property (sleep_request |-> !data_oe) else $error("drive while asleep");
    AST_FIRST_BEAT: assert property (st && !pipeline_chip_select_n && !output_enable_n ##1 global_write_n
        |-> ##[1:5] data_oe) else $error("read data late");
    AST_OUT_CAUSE: assert property (!$stable(data_out) |-> idle_reg < 4'h8) else $error("data moved unasked");
    AST_RESET_CLEAR: assert property (disable iff (1'b0) reset |-> !data_oe && data_out == '0)
        else $error("outputs live in reset");
    AST_DESELECT: assert property (st && pipeline_chip_select_n && !data_oe ##1 (!st && burst_advance_n)[*4]
        |-> !data_oe) else $error("deselected strobe drove");
    AST_ADV_IDLE: assert property (idle_reg == 4'hf && !data_oe && !burst_advance_n && !st ##1 (!st)[*3]
        |-> !data_oe) else $error("advance without burst drove");
    AST_WRITE_QUIET: assert property (st && !pipeline_chip_select_n && !data_oe ##1 !global_write_n
        |=> !data_oe[*2]) else $error("drive during write");
    COV_READ: cover property (st ##1 global_write_n ##[1:5] data_oe);
    COV_WRITE: cover property (st ##1 !global_write_n);
    COV_ADV: cover property (data_oe && !burst_advance_n);
endmodule : sram_port_asserts
bind flow_through_burst_sram_port sram_port_asserts #(.DATA_WIDTH(DATA_WIDTH)) chk (.clk_sys, .reset,
    .data_out, .data_oe, .pipeline_chip_select_n, .processor_addr_strobe_n, .controller_addr_strobe_n,
    .burst_advance_n, .global_write_n, .output_enable_n, .sleep_request);
`default_nettype wire

// ==== testbench/bus_controller_model.sv ====
/* Behavioural cache controller driving the synchronous side of the port.
   Assumes its tasks are called by one bench process. */
`timescale 1ns/1ps
`default_nettype none
module bus_controller_model #(parameter int unsigned AW = 18, parameter int unsigned DW = 36) (
    input  wire logic          clk_sys,
    input  wire logic [DW-1:0] data_out,
    input  wire logic          data_oe,
    output logic      [AW-1:0] address,
    output logic      [DW-1:0] data_in,
    output logic               pipeline_chip_select_n,
    output logic               processor_addr_strobe_n,
    output logic               controller_addr_strobe_n,
    output logic               burst_advance_n,
    output logic               global_write_n,
    output logic               burst_order
);
    logic          drive;
    logic [DW-1:0] wdata;
    // The controller's own write drive wins; a released bus shows the inverse
    // of the last beat's data, so stale data never passes.
    assign data_in = drive ? wdata : (data_oe ? data_out : ~wdata);
    initial begin
        {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n, global_write_n,
            pipeline_chip_select_n, burst_order, drive} = 7'h78;
        address = '0;
        wdata = '0;
    end
    task automatic strobe(input logic proc, input logic [AW-1:0] a, input logic sel, input logic il);
        @(posedge clk_sys);
        #1;
        {processor_addr_strobe_n, controller_addr_strobe_n} = {!proc, proc};
        pipeline_chip_select_n = !sel;
        address = a;
        burst_order = il;
    endtask : strobe
    task automatic beat(input logic burst_advance, input logic wr, input logic [DW-1:0] d);
        @(posedge clk_sys);
        #1;
        {processor_addr_strobe_n, controller_addr_strobe_n} = 2'h3;
        address = ~address;
        burst_advance_n = !burst_advance;
        global_write_n = !wr;
        drive = wr;
        wdata = d;
    endtask : beat
endmodule : bus_controller_model
`default_nettype wire

// ==== testbench/tb_flow_through_burst_sram_port.sv ====
/* Self-checking bench for the burst memory port.
   Assumes the controller model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_flow_through_burst_sram_port;
    localparam int unsigned AW = sram_port_pkg::ADDR_WIDTH_WIDE;
    localparam int unsigned DW = sram_port_pkg::DATA_WIDTH_WIDE;
    logic clk_sys, reset, output_enable_n, sleep_request;
    wire logic [AW-1:0] address;
    wire logic [DW-1:0] data_in, data_out;
    wire logic data_oe, pipeline_chip_select_n, processor_addr_strobe_n, controller_addr_strobe_n;
    wire logic burst_advance_n, global_write_n, burst_order;
    int n_errors, n_tests;
    flow_through_burst_sram_port uut (.clk_sys, .reset, .address, .data_in, .data_out, .data_oe,
        .pipeline_chip_select_n, .depth_select_b(1'b1), .depth_select_c_n(1'b0), .processor_addr_strobe_n,
        .controller_addr_strobe_n, .burst_advance_n, .byte_lane_write_n(4'hf), .byte_write_gate_n(1'b1),
        .global_write_n, .output_enable_n, .sleep_request, .burst_order);
    bus_controller_model #(.AW(AW), .DW(DW)) ctl (.clk_sys, .data_out, .data_oe, .address, .data_in,
        .pipeline_chip_select_n, .processor_addr_strobe_n, .controller_addr_strobe_n, .burst_advance_n,
        .global_write_n, .burst_order);
    ////////////////////////////////////////
    // Each location holds its own low address nibble, so any order slip shows.
    function automatic logic [DW-1:0] word(logic [AW-1:0] s, logic [1:0] i, logic il);
        logic [AW-1:0] a;
        a = {s[AW-1:2], il ? s[1:0] ^ i : s[1:0] + i};
        return {9{a[3:0]}};
    endfunction : word
    task automatic give_verdict();
        $display("comparisons %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    task automatic compare(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : compare
    ////////////////////////////////////////
    task automatic quiet_checks();
        ctl.beat(1'b1, 1'b0, '0);
        ctl.beat(1'b0, 1'b0, '0);
        repeat (4) @(posedge clk_sys);
        ctl.strobe(1'b0, 18'h3, 1'b0, 1'b0);
        ctl.beat(1'b0, 1'b0, '0);
        repeat (6) @(posedge clk_sys);
        #1 compare({35'h0, data_oe}, '0);
    endtask : quiet_checks
    task automatic write_burst(input logic proc, input logic [AW-1:0] s, input logic il);
        ctl.strobe(proc, s, 1'b1, il);
        for (int i = 0; i < 4; i++) ctl.beat(i > 0, 1'b1, word(s, 2'(i), il));
        ctl.beat(1'b0, 1'b0, '0);
        repeat (4) @(posedge clk_sys);
    endtask : write_burst
    task automatic read_burst(input logic proc, input logic [AW-1:0] s, input logic il);
        // Advance in the three cycles after the strobe: beats show at the
        // edges three, four, five and six cycles after the strobe edge.
        ctl.strobe(proc, s, 1'b1, il);
        repeat (3) ctl.beat(1'b1, 1'b0, '0);
        ctl.beat(1'b0, 1'b0, '0);
        compare({35'h0, data_oe}, 36'h1);
        for (int i = 0; i < 4; i++) begin
            if (i > 0) @(posedge clk_sys) #1;
            compare(data_out, word(s, 2'(i), il));
        end
    endtask : read_burst
    task automatic async_checks();
        @(posedge clk_sys) #1 output_enable_n = 1'b1;
        #1 compare({35'h0, data_oe}, '0);
        @(posedge clk_sys) #1 output_enable_n = 1'b0;
        sleep_request = 1'b1;
        #1 compare({35'h0, data_oe}, '0);
        @(posedge clk_sys) #1 sleep_request = 1'b0;
    endtask : async_checks
    ////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        {reset, output_enable_n, sleep_request} = 3'h4;
        n_errors = 0;
        n_tests = 0;
        repeat (20) @(posedge clk_sys);
        #1 reset = 1'b0;
        quiet_checks();
        write_burst(1'b0, 18'h6, 1'b0);
        write_burst(1'b1, 18'h9, 1'b1);
        read_burst(1'b1, 18'h5, 1'b0);
        read_burst(1'b0, 18'ha, 1'b1);
        async_checks();
        give_verdict();
    end
endmodule : tb_flow_through_burst_sram_port
`default_nettype wire
